// File: rtl/pmt_timer.v
// period match timer: prescaler, 8-bit counter with period compare, postscaler, registers
//
// What this block does
// - timer clocked only by instruction clock, oscillator divided by four, via prescaler
// - prescale select: 00 divides by one, 01 by four, 1x by sixteen
// - counter counts up from zero until equal to period, then wraps to zero
// - run bit 2 clear holds the counter; setting it resumes counting
// - postscale field bits 6..3 overflows every field plus one matches
// - postscaler overflow sets the match event flag
// - undivided period match pulse goes out to the serial block
// - writing counter or control clears prescaler and postscaler
// - writing control leaves the counter value untouched
// - every reset clears prescaler and postscaler
// - reset clears counter to zero and sets period to all ones
// - in sleep counter holds and prescaler keeps its partial count
// - control bit 7 reads zero; control resets to zero, timer off
// - counter and period registers readable and writable at any time
// - counter value and match pulse offered as pwm time base
`timescale 1ns/10ps
`include "pmt_defines.vh"

module pmt_timer #(
	parameter OSC_DIV = `PMT_OSC_DIV
) (
	input  wire                   mclk,
	input  wire                   sys_rst,
	input  wire                   sleep_mode,
	input  wire [`PMT_ADDR_W-1:0] reg_addr,
	input  wire [7:0]             reg_wdata,
	input  wire                   reg_wr,
	input  wire                   reg_rd,
	output reg  [7:0]             reg_rdata,
	output reg                    irq,
	output reg                    serial_shift_tick,
	output reg                    pwm_match_tick,
	output reg  [7:0]             pwm_count
);

	// last phase of the oscillator divider; two bits wide, so OSC_DIV
	// must stay between one and four
	localparam integer ICYC_LAST_I = OSC_DIV - 1;
	localparam [1:0]   ICYC_LAST   = ICYC_LAST_I[1:0];

	// architectural registers
	reg [7:0] ctl_ff;
	reg [7:0] count_ff;
	reg [7:0] period_ff;
	reg       match_flag_ff;
	reg       match_en_ff;

	// scaler state
	reg [1:0] osc_div_ff;
	wire [3:0] pre_ff;
	wire [3:0] post_ff;

	// next values
	reg [7:0] nxt_ctl;
	reg [7:0] nxt_count;
	reg [7:0] nxt_period;
	reg       nxt_match_flag;
	reg       nxt_match_en;
	reg [1:0] nxt_osc_div;
	reg       nxt_match;
	reg       nxt_irq;
	reg [7:0] nxt_rdata;

	// combinational helpers
	reg [3:0] pre_max;
	reg       wrap;
	reg       scaler_clr;
	reg       flag_clr;
	wire      inc_tick;
	wire      post_ovf;

	// register bus decode
	wire       wr_ctl    = reg_wr && (reg_addr == `PMT_OFF_CONTROL);
	wire       wr_count  = reg_wr && (reg_addr == `PMT_OFF_COUNT);
	wire       wr_period = reg_wr && (reg_addr == `PMT_OFF_PERIOD);
	wire       wr_ien    = reg_wr && (reg_addr == `PMT_OFF_IRQ_ENABLE);
	wire       wr_iclr   = reg_wr && (reg_addr == `PMT_OFF_IRQ_CLEAR);

	// control fields
	wire       run       = ctl_ff[`PMT_CTL_RUN];
	wire [1:0] pre_sel   = ctl_ff[`PMT_CTL_PRE_HI:`PMT_CTL_PRE_LO];
	wire [3:0] post_sel  = ctl_ff[`PMT_CTL_POST_HI:`PMT_CTL_POST_LO];
	// sleep freezes both counter and prescaler
	wire       active    = run && !sleep_mode;
	// instruction cycle: one tick every OSC_DIV clocks of mclk
	wire       icyc      = (osc_div_ff == ICYC_LAST);
	wire       pre_step  = active && icyc;

	// free-running divider, never cleared by software
	always @*
	begin
		nxt_osc_div = icyc ? 2'h0 : osc_div_ff + 2'h1;
	end

	always @(posedge mclk)
	begin
		if (sys_rst)
			osc_div_ff <= 2'h0;
		else
			osc_div_ff <= nxt_osc_div;
	end

	always @*
	begin
		case (pre_sel)
			`PMT_PRE_DIV1: pre_max = 4'h0;
			`PMT_PRE_DIV4: pre_max = `PMT_PRE_MAX4;
			default:       pre_max = `PMT_PRE_MAX16;
		endcase
	end

	// any control or count write restarts both scalers
	always @*
	begin
		scaler_clr = wr_ctl || wr_count;
	end

	// compare is >=; a new ratio comes only with a control write, which restarts the scaler from zero
	pmt_scaler #(
		.W (4)
	) u_pmt_pre (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.clr     (scaler_clr),
		.step    (pre_step),
		.limit   (pre_max),
		.cnt_ff  (pre_ff),
		.ovf     (inc_tick)
	);

	always @*
	begin
		wrap      = inc_tick && (count_ff == period_ff);
		nxt_count = count_ff;
		if (wr_count)
			nxt_count = reg_wdata;
		else if (wrap)
			nxt_count = 8'h00;
		else if (inc_tick)
			nxt_count = count_ff + 8'h01;
	end

	always @(posedge mclk)
	begin
		if (sys_rst)
			count_ff <= `PMT_RST_COUNT;
		else
			count_ff <= nxt_count;
	end

	// wrap suppressed when software overwrites counter in the same cycle
	always @*
	begin
		nxt_match = wrap && !wr_count;
	end

	pmt_scaler #(
		.W (4)
	) u_pmt_post (
		.mclk    (mclk),
		.sys_rst (sys_rst),
		.clr     (scaler_clr),
		.step    (nxt_match),
		.limit   (post_sel),
		.cnt_ff  (post_ff),
		.ovf     (post_ovf)
	);

	// set beats a coincident clear so no overflow is ever lost
	always @*
	begin
		flag_clr       = wr_iclr && reg_wdata[`PMT_IRQ_MATCH];
		nxt_match_flag = match_flag_ff;
		if (flag_clr)
			nxt_match_flag = 1'b0;
		if (post_ovf)
			nxt_match_flag = 1'b1;
	end

	always @(posedge mclk)
	begin
		if (sys_rst)
			match_flag_ff <= 1'b0;
		else
			match_flag_ff <= nxt_match_flag;
	end

	always @*
	begin
		nxt_match_en = wr_ien ? reg_wdata[`PMT_IRQ_MATCH] : match_en_ff;
	end

	always @(posedge mclk)
	begin
		if (sys_rst)
			match_en_ff <= 1'b0;
		else
			match_en_ff <= nxt_match_en;
	end

	// unimplemented bit 7 is masked on the way in and on the way out
	always @*
	begin
		nxt_ctl = wr_ctl ? (reg_wdata & `PMT_CTL_MASK) : ctl_ff;
	end

	always @(posedge mclk)
	begin
		if (sys_rst)
			ctl_ff <= `PMT_RST_CONTROL;
		else
			ctl_ff <= nxt_ctl;
	end

	always @*
	begin
		nxt_period = wr_period ? reg_wdata : period_ff;
	end

	always @(posedge mclk)
	begin
		if (sys_rst)
			period_ff <= `PMT_RST_PERIOD;
		else
			period_ff <= nxt_period;
	end

	// irq follows next-state flag and enable so it lines up with the flag
	always @*
	begin
		nxt_irq = nxt_match_flag && nxt_match_en;
	end

	// read data is zero outside the slot after a read strobe
	always @*
	begin
		nxt_rdata = 8'h00;
		if (reg_rd)
		begin
			case (reg_addr)
				`PMT_OFF_CONTROL:    nxt_rdata = ctl_ff & `PMT_CTL_MASK;
				`PMT_OFF_COUNT:      nxt_rdata = count_ff;
				`PMT_OFF_PERIOD:     nxt_rdata = period_ff;
				`PMT_OFF_IRQ_STATUS: nxt_rdata = {7'h00, match_flag_ff};
				`PMT_OFF_IRQ_ENABLE: nxt_rdata = {7'h00, match_en_ff};
				default:             nxt_rdata = 8'h00;
			endcase
		end
	end

	always @(posedge mclk)
	begin
		if (sys_rst)
			reg_rdata <= 8'h00;
		else
			reg_rdata <= nxt_rdata;
	end

	always @(posedge mclk)
	begin
		if (sys_rst)
			irq <= 1'b0;
		else
			irq <= nxt_irq;
	end

	// shift clock option for the serial block, taken before the postscaler
	always @(posedge mclk)
	begin
		if (sys_rst)
			serial_shift_tick <= 1'b0;
		else
			serial_shift_tick <= nxt_match;
	end

	// pwm units get their own copy so their loading stays separate
	always @(posedge mclk)
	begin
		if (sys_rst)
			pwm_match_tick <= 1'b0;
		else
			pwm_match_tick <= nxt_match;
	end

	always @(posedge mclk)
	begin
		if (sys_rst)
			pwm_count <= `PMT_RST_COUNT;
		else
			pwm_count <= nxt_count;
	end

endmodule

// step counter shared by the prescaler and the postscaler
module pmt_scaler #(
	parameter W = 4
) (
	input  wire         mclk,
	input  wire         sys_rst,
	input  wire         clr,
	input  wire         step,
	input  wire [W-1:0] limit,
	output reg  [W-1:0] cnt_ff,
	output reg          ovf
);

	reg [W-1:0] nxt_cnt;

	// clear wins over a step so a restart never leaks an overflow
	always @*
	begin
		ovf     = 1'b0;
		nxt_cnt = cnt_ff;
		if (clr)
			nxt_cnt = {W{1'b0}};
		else if (step)
		begin
			if (cnt_ff >= limit)
			begin
				nxt_cnt = {W{1'b0}};
				ovf     = 1'b1;
			end
			else
				nxt_cnt = cnt_ff + {{(W-1){1'b0}}, 1'b1};
		end
	end

	always @(posedge mclk)
	begin
		if (sys_rst)
			cnt_ff <= {W{1'b0}};
		else
			cnt_ff <= nxt_cnt;
	end

endmodule

// File: rtl/pmt_defines.vh
// register map, field positions, reset values and clock figures of the period match timer
`ifndef PMT_DEFINES_VH
`define PMT_DEFINES_VH

`define PMT_ADDR_W          3
`define PMT_OFF_CONTROL     3'h0
`define PMT_OFF_COUNT       3'h1
`define PMT_OFF_PERIOD      3'h2
`define PMT_OFF_IRQ_STATUS  3'h3
`define PMT_OFF_IRQ_ENABLE  3'h4
`define PMT_OFF_IRQ_CLEAR   3'h5

`define PMT_CTL_PRE_LO      0
`define PMT_CTL_PRE_HI      1
`define PMT_CTL_RUN         2
`define PMT_CTL_POST_LO     3
`define PMT_CTL_POST_HI     6
`define PMT_CTL_MASK        8'h7F

`define PMT_RST_CONTROL     8'h00
`define PMT_RST_COUNT       8'h00
`define PMT_RST_PERIOD      8'hFF

`define PMT_IRQ_MATCH       0

`define PMT_PRE_DIV1        2'h0
`define PMT_PRE_DIV4        2'h1

`define PMT_OSC_DIV         4
`define PMT_PRE_MAX4        4'h3
`define PMT_PRE_MAX16       4'hF

`endif

// File: dv/pmt_chk.sv
// port assertions for the period match timer
`timescale 1ns/10ps
`include "pmt_defines.vh"
module pmt_chk (
	input wire                   mclk,
	input wire                   sys_rst,
	input wire                   sleep_mode,
	input wire [`PMT_ADDR_W-1:0] reg_addr,
	input wire [7:0]             reg_wdata,
	input wire                   reg_wr,
	input wire                   reg_rd,
	input wire [7:0]             reg_rdata,
	input wire                   irq,
	input wire                   serial_shift_tick,
	input wire                   pwm_match_tick,
	input wire [7:0]             pwm_count
);
default clocking @(posedge mclk); endclocking
default disable iff (sys_rst);
property p_rd0; reg_rdata != 8'h00 |-> $past(reg_rd); endproperty
a_rd0: assert property (p_rd0) else $error("read data outside slot");
property p_gap; serial_shift_tick |=> !serial_shift_tick [*3]; endproperty
a_gap: assert property (p_gap) else $error("ticks too close");
property p_twin; pwm_match_tick == serial_shift_tick; endproperty
a_twin: assert property (p_twin) else $error("tick outputs differ");
property p_wrap; serial_shift_tick |-> pwm_count == 8'h00; endproperty
a_wrap: assert property (p_wrap) else $error("tick without wrap");
property p_sleep; (sleep_mode && !reg_wr) [*3] |=> $stable(pwm_count); endproperty
a_sleep: assert property (p_sleep) else $error("count moved asleep");
property p_irq; $rose(irq) |-> serial_shift_tick || $past(reg_wr) || $past(reg_wr, 2); endproperty
a_irq: assert property (p_irq) else $error("irq without match");
property p_rst; $fell(sys_rst) |-> pwm_count == 8'h00 && !irq && reg_rdata == 8'h00; endproperty
a_rst: assert property (p_rst) else $error("reset values wrong");
property p_step;
	!$past(reg_wr) && !$past(reg_wr, 2) && $changed(pwm_count)
		|-> pwm_count == $past(pwm_count) + 8'h01 || pwm_count == 8'h00;
endproperty
a_step: assert property (p_step) else $error("count skipped");
c_tick: cover property (serial_shift_tick);
c_irq: cover property ($rose(irq));
c_sleep: cover property (sleep_mode [*3]);
endmodule
bind pmt_timer pmt_chk u_pmt_chk (.mclk, .sys_rst, .sleep_mode, .reg_addr, .reg_wdata,
	.reg_wr, .reg_rd, .reg_rdata, .irq, .serial_shift_tick, .pwm_match_tick, .pwm_count);

// File: dv/pmt_timer_test.sv
// self-checking bench for the period match timer
`timescale 1ns/10ps
module pmt_timer_test;
logic       mclk, sys_rst, sleep_mode, reg_wr, reg_rd, irq;
logic       serial_shift_tick, pwm_match_tick;
logic [2:0] reg_addr;
logic [7:0] reg_wdata, reg_rdata, pwm_count;
int         mismatches, num_checks;
pmt_timer u_pmt_timer (.mclk, .sys_rst, .sleep_mode, .reg_addr, .reg_wdata, .reg_wr,
	.reg_rd, .reg_rdata, .irq, .serial_shift_tick, .pwm_match_tick, .pwm_count);
task summarize;
	$display("checks %0d mismatches %0d", num_checks, mismatches);
	if (mismatches == 0 && num_checks > 0)
		$display("SIMULATION PASSED");
	else
		$display("SIMULATION FAILED");
	$finish;
endtask
task chk(string s, logic [15:0] e, logic [15:0] g);
	num_checks++;
	if (g !== e)
	begin
		mismatches++;
		$display("MISMATCH %s exp %h got %h", s, e, g);
	end
endtask
task wr(logic [2:0] a, logic [7:0] d);
	@(posedge mclk);
	reg_addr <= a;
	reg_wdata <= d;
	reg_wr <= 1'b1;
	@(posedge mclk);
	reg_wr <= 1'b0;
endtask
task rd(logic [2:0] a, logic [7:0] e);
	@(posedge mclk);
	reg_addr <= a;
	reg_rd <= 1'b1;
	@(posedge mclk);
	reg_rd <= 1'b0;
	#1 chk("rdata", {8'h00, e}, {8'h00, reg_rdata});
endtask
// cycles up to the next match tick; a lost tick ends the run
task gap(output int c);
	c = 1;
	@(negedge mclk);
	while (serial_shift_tick !== 1'b1)
	begin
		@(negedge mclk);
		c++;
		if (c > 600)
		begin
			mismatches++;
			summarize;
		end
	end
endtask
task t_scales;
	int c;
	wr(3'h2, 8'h03);
	for (int p = 0; p < 4; p++)
	begin
		wr(3'h0, 8'h04 | 8'(p));
		gap(c);
		gap(c);
		chk("gap", 16'(16 * (p == 0 ? 1 : p == 1 ? 4 : 16)), 16'(c));
	end
	$display("scale test done");
endtask
task t_post(logic [3:0] f);
	int c, n;
	wr(3'h0, 8'h00);
	wr(3'h5, 8'h01);
	wr(3'h4, 8'h01);
	wr(3'h0, {1'b0, f, 3'h4});
	n = 0;
	do
	begin
		gap(c);
		@(negedge mclk);
		n++;
	end while (irq !== 1'b1 && n < 20);
	chk("matches", 16'(f + 1), 16'(n));
	wr(3'h0, 8'h00);
	rd(3'h3, 8'h01);
	wr(3'h4, 8'h00);
	rd(3'h4, 8'h00);
	chk("irq", 16'h0000, {15'h0000, irq});
	wr(3'h5, 8'h01);
	rd(3'h3, 8'h00);
	$display("postscale test done");
endtask
task t_hold;
	wr(3'h2, 8'hFF);
	wr(3'h1, 8'h05);
	wr(3'h0, 8'h78);
	rd(3'h1, 8'h05);
	repeat (40) @(posedge mclk);
	rd(3'h1, 8'h05);
	@(posedge mclk);
	sleep_mode <= 1'b1;
	wr(3'h0, 8'h04);
	repeat (40) @(posedge mclk);
	rd(3'h1, 8'h05);
	chk("count", 16'h0005, {8'h00, pwm_count});
	@(posedge mclk);
	sleep_mode <= 1'b0;
	$display("hold test done");
endtask
initial
begin
	mclk = 1'b0;
	forever #2.5 mclk = ~mclk;
end
initial
begin
	{sys_rst, sleep_mode, reg_wr, reg_rd, reg_addr, reg_wdata} = 15'h4000;
	repeat (3) @(posedge mclk);
	sys_rst <= 1'b0;
	rd(3'h0, 8'h00);
	rd(3'h1, 8'h00);
	rd(3'h2, 8'hFF);
	rd(3'h6, 8'h00);
	wr(3'h0, 8'hFF);
	rd(3'h0, 8'h7F);
	t_scales;
	t_post(4'h0);
	t_post(4'hF);
	t_hold;
	summarize;
end
endmodule
